/* File: rtl/ieg_gate.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ieg_map.svh"

module ieg_gate (
  input wire logic clock,
  input wire logic rst,
  // Watchdog or stack-overflow reset from the core, same clock
  input wire logic watchdog_stack_fault_reset,
  // Global enable state set by the enable instruction, same clock
  input wire logic global_irq_enable_instr,
  // Request flags from the peripheral flag registers, same clock
  input wire logic [`IEG_SRC_N-1:0] per_source_flag,
  // AXI4-Lite slave
  input wire logic [`IEG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`IEG_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`IEG_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`IEG_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Acceptance request to the core with its branch address
  output logic irq_request,
  output logic [`IEG_VEC_W-1:0] irq_vector
);

  // Address to register select; protection bits are not checked
  function automatic ieg_pkg::ieg_sel_t decode(input logic [`IEG_ADDR_W-1:0] a);
    logic [`IEG_ADDR_W-1:0] idx;
    idx = {2'h0, a[`IEG_ADDR_W-1:2]};
    if (a[1:0] != 2'h0) begin
      decode = ieg_pkg::IEG_SEL_NONE;
    end else if (idx == `IEG_IDX_EN1) begin
      decode = ieg_pkg::IEG_SEL_EN1;
    end else if (idx == `IEG_IDX_EN2) begin
      decode = ieg_pkg::IEG_SEL_EN2;
    end else if (idx == `IEG_IDX_EN3) begin
      decode = ieg_pkg::IEG_SEL_EN3;
    end else if (idx == `IEG_IDX_STAT) begin
      decode = ieg_pkg::IEG_SEL_STAT;
    end else begin
      decode = ieg_pkg::IEG_SEL_NONE;
    end
  endfunction

  // Write channel state
  ieg_pkg::ieg_wr_state_t wr_state_ff;
  ieg_pkg::ieg_wr_state_t nxt_wr_state;
  // Address and data captured in either order
  logic aw_got_ff;
  logic w_got_ff;
  logic [`IEG_ADDR_W-1:0] aw_addr_ff;
  logic [`IEG_EN_W-1:0] w_data_ff;
  logic w_lane0_ff;
  // Handshake outputs, all registered
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  // Read channel
  ieg_pkg::ieg_rd_state_t rd_state_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [`IEG_DATA_W-1:0] rdata_ff;
  logic [1:0] rresp_ff;
  // Channel handshakes this cycle
  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic ar_hs;
  logic r_hs;
  // Decoded write target, valid in exec state
  ieg_pkg::ieg_sel_t wr_sel;
  // Per-register write enables, one-cycle pulses
  logic [2:0] en_wr;
  // The three enable registers
  logic [`IEG_EN_W-1:0] en_q [3];
  // Enables laid out in source order
  logic [`IEG_SRC_N-1:0] src_mask;
  // Sources passing all three conditions
  logic [`IEG_SRC_N-1:0] gated;
  // Picker outputs
  logic pick_any;
  logic [`IEG_IDX_W-1:0] pick_idx;
  logic [`IEG_VEC_W-1:0] pick_vec;
  // Registered acceptance outputs
  logic irq_request_ff;
  logic [`IEG_VEC_W-1:0] irq_vector_ff;

  assign aw_hs = s_axi_awvalid && awready_ff;
  assign w_hs = s_axi_wvalid && wready_ff;
  assign b_hs = bvalid_ff && s_axi_bready;
  assign ar_hs = s_axi_arvalid && arready_ff;
  assign r_hs = rvalid_ff && s_axi_rready;
  assign wr_sel = decode(aw_addr_ff);

  // Write sequencing: gather both halves, write once, then answer
  always_comb begin
    nxt_wr_state = wr_state_ff;
    case (wr_state_ff)
      ieg_pkg::IEG_WR_IDLE: begin
        if ((aw_got_ff || aw_hs) && (w_got_ff || w_hs)) begin
          nxt_wr_state = ieg_pkg::IEG_WR_EXEC;
        end
      end
      ieg_pkg::IEG_WR_EXEC: begin
        nxt_wr_state = ieg_pkg::IEG_WR_RESP;
      end
      ieg_pkg::IEG_WR_RESP: begin
        if (b_hs) begin
          nxt_wr_state = ieg_pkg::IEG_WR_IDLE;
        end
      end
      default: begin
        nxt_wr_state = ieg_pkg::IEG_WR_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_state_ff <= ieg_pkg::IEG_WR_IDLE;
    end else begin
      wr_state_ff <= nxt_wr_state;
    end
  end

  // Address capture; awready drops on the handshake so only one write is held
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_got_ff <= 1'b0;
      aw_addr_ff <= '0;
      awready_ff <= 1'b0;
    end else if (aw_hs) begin
      aw_got_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
      awready_ff <= 1'b0;
    end else if (b_hs) begin
      aw_got_ff <= 1'b0;
    end else if (wr_state_ff == ieg_pkg::IEG_WR_IDLE && !aw_got_ff) begin
      awready_ff <= 1'b1;
    end
  end

  // Data capture; only lane 0 carries register bits
  always_ff @(posedge clock) begin
    if (rst) begin
      w_got_ff <= 1'b0;
      w_data_ff <= '0;
      w_lane0_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else if (w_hs) begin
      w_got_ff <= 1'b1;
      w_data_ff <= s_axi_wdata[`IEG_EN_W-1:0];
      w_lane0_ff <= s_axi_wstrb[0];
      wready_ff <= 1'b0;
    end else if (b_hs) begin
      w_got_ff <= 1'b0;
    end else if (wr_state_ff == ieg_pkg::IEG_WR_IDLE && !w_got_ff) begin
      wready_ff <= 1'b1;
    end
  end

  always_comb begin
    en_wr = 3'h0;
    if (wr_state_ff == ieg_pkg::IEG_WR_EXEC && w_lane0_ff) begin
      case (wr_sel)
        ieg_pkg::IEG_SEL_EN1: en_wr = 3'h1;
        ieg_pkg::IEG_SEL_EN2: en_wr = 3'h2;
        ieg_pkg::IEG_SEL_EN3: en_wr = 3'h4;
        default: en_wr = 3'h0;
      endcase
    end
  end

  // Write response; status is read-only, so a write to it is refused too
  always_ff @(posedge clock) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `IEG_RESP_OKAY;
    end else if (wr_state_ff == ieg_pkg::IEG_WR_EXEC) begin
      bvalid_ff <= 1'b1;
      if (wr_sel == ieg_pkg::IEG_SEL_STAT || wr_sel == ieg_pkg::IEG_SEL_NONE) begin
        bresp_ff <= `IEG_RESP_SLVERR;
      end else begin
        bresp_ff <= `IEG_RESP_OKAY;
      end
    end else if (b_hs) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Enable registers; a fault reset beats a write landing in the same cycle
  for (genvar g = 0; g < 3; g++) begin : g_en
    ieg_mask_reg u_en (
      .clock(clock),
      .rst(rst),
      .fault_clr(watchdog_stack_fault_reset),
      .wr_en(en_wr[g]),
      .wr_data(w_data_ff),
      .q_ff(en_q[g])
    );
  end

  // Spread register bits over source positions
  always_comb begin
    src_mask = '0;
    src_mask[`IEG_SRC_TM2] = en_q[0][0];
    src_mask[`IEG_SRC_TM3] = en_q[0][1];
    src_mask[`IEG_SRC_SER0] = en_q[0][2];
    src_mask[`IEG_SRC_SER1] = en_q[0][3];
    src_mask[`IEG_SRC_PIN3] = en_q[1][0];
    src_mask[`IEG_SRC_PIN4] = en_q[1][1];
    src_mask[`IEG_SRC_TM0] = en_q[1][2];
    src_mask[`IEG_SRC_TM1] = en_q[1][3];
    src_mask[`IEG_SRC_CE] = en_q[2][0];
    src_mask[`IEG_SRC_PIN0] = en_q[2][1];
    src_mask[`IEG_SRC_PIN1] = en_q[2][2];
    src_mask[`IEG_SRC_PIN2] = en_q[2][3];
  end

  assign gated = global_irq_enable_instr ? (per_source_flag & src_mask) : '0;

  // Vector generator
  ieg_vecgen u_vec (
    .gated(gated),
    .any(pick_any),
    .idx(pick_idx),
    .vector(pick_vec)
  );

  // Request follows gating each cycle; the core clears the flag it takes
  // register branch address
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_request_ff <= 1'b0;
      irq_vector_ff <= '0;
    end else begin
      irq_request_ff <= pick_any;
      irq_vector_ff <= pick_any ? pick_vec : '0;
    end
  end

  // Read: address taken, data one cycle later, held until rready
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_state_ff <= ieg_pkg::IEG_RD_IDLE;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= `IEG_RESP_OKAY;
    end else begin
      case (rd_state_ff)
        ieg_pkg::IEG_RD_IDLE: begin
          if (ar_hs) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rd_state_ff <= ieg_pkg::IEG_RD_RESP;
            rresp_ff <= `IEG_RESP_OKAY;
            rdata_ff <= '0;
            case (decode(s_axi_araddr))
              ieg_pkg::IEG_SEL_EN1: rdata_ff[`IEG_EN_W-1:0] <= en_q[0];
              ieg_pkg::IEG_SEL_EN2: rdata_ff[`IEG_EN_W-1:0] <= en_q[1];
              ieg_pkg::IEG_SEL_EN3: rdata_ff[`IEG_EN_W-1:0] <= en_q[2];
              ieg_pkg::IEG_SEL_STAT: begin
                rdata_ff[`IEG_SRC_N-1:0] <= gated;
                rdata_ff[`IEG_STAT_GIE] <= global_irq_enable_instr;
                rdata_ff[`IEG_STAT_RAW_LO +: `IEG_SRC_N] <= per_source_flag;
              end
              default: rresp_ff <= `IEG_RESP_SLVERR;
            endcase
          end else begin
            arready_ff <= 1'b1;
          end
        end
        ieg_pkg::IEG_RD_RESP: begin
          if (r_hs) begin
            rvalid_ff <= 1'b0;
            rd_state_ff <= ieg_pkg::IEG_RD_IDLE;
          end
        end
        default: begin
          rd_state_ff <= ieg_pkg::IEG_RD_IDLE;
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign irq_request = irq_request_ff;
  assign irq_vector = irq_vector_ff;

  // Checks, all on the one clock, idle during reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // A source is pending while enabled, flagged and globally allowed
  sequence s_pending;
    global_irq_enable_instr && (|(per_source_flag & src_mask));
  endsequence

  // The request answers one cycle later
  sequence s_raised;
    irq_request_ff;
  endsequence

  a_accept_gate: assert property ($rose(irq_request_ff) |-> $past(global_irq_enable_instr))
    else $error("request raised without global enable");

  a_accept_seq: assert property (s_pending |=> s_raised)
    else $error("pending source not requested");

  // A fault reset in the same cycle wins over the write, so it is left out here
  a_reg_store: assert property (en_wr[0] && !watchdog_stack_fault_reset
    |=> en_q[0] == $past(w_data_ff))
    else $error("enable register one write lost");

  a_tm2_mask: assert property (
    irq_request_ff && irq_vector_ff == 12'h004 |-> $past(en_q[0][0]))
    else $error("timer two accepted while disabled");

  a_ser1_mask: assert property (
    irq_request_ff && irq_vector_ff == 12'h001 |-> $past(en_q[0][3]))
    else $error("serial one accepted while disabled");

  a_pin3_mask: assert property (
    irq_request_ff && irq_vector_ff == 12'h008 |-> $past(en_q[1][0]))
    else $error("pin three accepted while disabled");

  a_tm1_mask: assert property (
    irq_request_ff && irq_vector_ff == 12'h005 |-> $past(en_q[1][3]))
    else $error("timer one accepted while disabled");

  a_ce_first: assert property (
    global_irq_enable_instr && per_source_flag[`IEG_SRC_CE] && en_q[2][0]
    |=> irq_request_ff && irq_vector_ff == `IEG_VEC_CE)
    else $error("chip-enable source not taken at its vector");

  a_pin0_mask: assert property (
    irq_request_ff && irq_vector_ff == 12'h00b |-> $past(en_q[2][1]))
    else $error("pin zero accepted while disabled");

  a_fault_clear: assert property (watchdog_stack_fault_reset |=>
    en_q[0] == 4'h0 && en_q[1] == 4'h0 && en_q[2] == 4'h0)
    else $error("enables survive fault reset");

  a_vec_range: assert property (s_raised |-> irq_vector_ff >= `IEG_VEC_SER1
    && irq_vector_ff <= `IEG_VEC_CE && $past(pick_vec) == irq_vector_ff)
    else $error("vector out of table");

endmodule
`default_nettype wire

/* File: common/ieg_map.svh */
`ifndef IEG_MAP_SVH
`define IEG_MAP_SVH

// Bus geometry
`define IEG_ADDR_W 8
`define IEG_DATA_W 32

// Register indices; byte address is four times the index
`define IEG_IDX_EN1 8'h2d
`define IEG_IDX_EN2 8'h2e
`define IEG_IDX_EN3 8'h2f
`define IEG_IDX_STAT 8'h30

// Enable register width and reset value
`define IEG_EN_W 4
`define IEG_EN_RST 4'h0

// Source count, one bit per source, bit i answers at vector i+1
`define IEG_SRC_N 12
`define IEG_IDX_W 4
`define IEG_VEC_W 12

// Source positions in the source vector
`define IEG_SRC_SER1 0
`define IEG_SRC_SER0 1
`define IEG_SRC_TM3 2
`define IEG_SRC_TM2 3
`define IEG_SRC_TM1 4
`define IEG_SRC_TM0 5
`define IEG_SRC_PIN4 6
`define IEG_SRC_PIN3 7
`define IEG_SRC_PIN2 8
`define IEG_SRC_PIN1 9
`define IEG_SRC_PIN0 10
`define IEG_SRC_CE 11

// Vector addresses of the end points of the table
`define IEG_VEC_CE 12'h00c
`define IEG_VEC_SER1 12'h001

// Status register field positions
`define IEG_STAT_GIE 12
`define IEG_STAT_RAW_LO 16

// Bus responses
`define IEG_RESP_OKAY 2'h0
`define IEG_RESP_SLVERR 2'h2

`endif

/* File: common/ieg_pkg.sv */
package ieg_pkg;

  // Write channel sequencing, Gray coded along idle, exec, resp
  typedef enum logic [1:0] {
    IEG_WR_IDLE = 2'h0,
    IEG_WR_EXEC = 2'h1,
    IEG_WR_RESP = 2'h3
  } ieg_wr_state_t;

  // Read channel sequencing
  typedef enum logic {
    IEG_RD_IDLE = 1'h0,
    IEG_RD_RESP = 1'h1
  } ieg_rd_state_t;

  // Register selected by an address
  typedef enum logic [2:0] {
    IEG_SEL_EN1 = 3'h0,
    IEG_SEL_EN2 = 3'h1,
    IEG_SEL_EN3 = 3'h2,
    IEG_SEL_STAT = 3'h3,
    IEG_SEL_NONE = 3'h4
  } ieg_sel_t;

endpackage

/* File: rtl/ieg_mask_reg.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ieg_map.svh"

// One four-bit enable register of the register file
module ieg_mask_reg (
  input wire logic clock,
  input wire logic rst,
  input wire logic fault_clr,
  input wire logic wr_en,
  input wire logic [`IEG_EN_W-1:0] wr_data,
  output logic [`IEG_EN_W-1:0] q_ff
);

  // Power-on and watchdog or stack fault clear; other resets never reach here,
  // so chip-enable reset and clock stop leave the contents alone
  // clear on resets
  always_ff @(posedge clock) begin
    if (rst || fault_clr) begin
      q_ff <= `IEG_EN_RST;
    end else if (wr_en) begin
      q_ff <= wr_data;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/ieg_vecgen.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ieg_map.svh"

// Picks one accepted source and forms its branch address
module ieg_vecgen (
  input wire logic [`IEG_SRC_N-1:0] gated,
  output logic any,
  output logic [`IEG_IDX_W-1:0] idx,
  output logic [`IEG_VEC_W-1:0] vector
);

  // Highest source index wins, so the chip-enable edge goes first
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = 0; i < `IEG_SRC_N; i++) begin
      if (gated[i]) begin
        any = 1'b1;
        idx = `IEG_IDX_W'(i);
      end
    end
  end

  assign vector = `IEG_VEC_W'(idx) + `IEG_VEC_SER1;

endmodule
`default_nettype wire

/* File: dv/ieg_periph_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ieg_map.svh"

// Stands in for the peripheral flag registers and the core's global enable
module ieg_periph_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [`IEG_SRC_N-1:0] flags_in,
  input wire logic gie_in,
  output logic [`IEG_SRC_N-1:0] per_source_flag,
  output logic global_irq_enable_instr
);
  // Values change only on a load, as one core instruction would change them
  always_ff @(posedge clock) begin
    if (rst) begin
      per_source_flag <= '0;
      global_irq_enable_instr <= 1'b0;
    end else if (load) begin
      per_source_flag <= flags_in;
      global_irq_enable_instr <= gie_in;
    end
  end
endmodule
`default_nettype wire

/* File: dv/interrupt_enable_gating_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ieg_map.svh"

module interrupt_enable_gating_tb_top;
  logic clock, rst, wsf_rst, m_load, m_gie, gie;
  logic [11:0] m_flags, flags, irq_vector;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_request;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] en [3]; // Shadow of the three enable registers
  int miscompares, check_count, cycles;
  // Byte addresses are four times the register index
  logic [7:0] addr [4] = '{8'(`IEG_IDX_EN1 << 2), 8'(`IEG_IDX_EN2 << 2),
                          8'(`IEG_IDX_EN3 << 2), 8'(`IEG_IDX_STAT << 2)};

  // Flags and global enable come through the partner, bus straight in
  ieg_periph_model i_ieg_periph_model (.clock, .rst, .load(m_load), .flags_in(m_flags),
    .gie_in(m_gie), .per_source_flag(flags), .global_irq_enable_instr(gie));
  ieg_gate i_ieg_gate (.clock, .rst, .watchdog_stack_fault_reset(wsf_rst),
    .global_irq_enable_instr(gie), .per_source_flag(flags), .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_request, .irq_vector);

  // Free running 40 MHz clock
  always #12.5 clock = ~clock;

  // Hang guard, far above the twelve hundred or so cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // Xorshift step for repeatable stimulus
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Request and vector expected from shadow enables, flags and global enable
  function automatic logic [12:0] exp_irq(logic [11:0] f, logic g);
    logic [11:0] m;
    logic [12:0] r;
    m = {en[2][0], en[2][1], en[2][2], en[2][3], en[1][0], en[1][1], en[1][2], en[1][3],
         en[0][0], en[0][1], en[0][2], en[0][3]} & f & {12{g}};
    r = 13'h0000;
    // Highest vector wins, so the last hit in ascending order stays
    for (int i = 0; i < 12; i++) if (m[i]) r = {1'b1, 12'(i + 1)};
    return r;
  endfunction

  task automatic chk_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic chk_irq(input logic [12:0] ex);
    check_count++;
    if ({irq_request, irq_vector} !== ex) begin
      miscompares++;
      $display("ERROR irq expected %h seen %h", ex, {irq_request, irq_vector});
    end
  endtask

  // Write: address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [3:0] d, input logic [1:0] er);
    bit ad, wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {seed[31:4], d}; // Upper lanes carry noise, they must be ignored
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clock);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!s_axi_bvalid);
    chk_val("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  // Read: data compared only when an OKAY answer is expected
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    chk_val("rresp", 32'(er), 32'(s_axi_rresp));
    if (er === `IEG_RESP_OKAY) chk_val("rdata", ed, s_axi_rdata);
  endtask

  task automatic set_en(input logic [3:0] e1, input logic [3:0] e2, input logic [3:0] e3);
    en[0] = e1;
    en[1] = e2;
    en[2] = e3;
    for (int i = 0; i < 3; i++) axi_wr(addr[i], en[i], `IEG_RESP_OKAY);
  endtask

  // Partner loads at the next edge, gate answers one edge later
  task automatic set_src(input logic [11:0] f, input logic g);
    m_flags <= f;
    m_gie <= g;
    m_load <= 1'b1;
    @(posedge clock);
    m_load <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic rd_all;
    for (int i = 0; i < 3; i++) axi_rd(addr[i], {28'h0, en[i]}, `IEG_RESP_OKAY);
  endtask

  task automatic summarize;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    logic [11:0] f;
    logic g;
    {clock, wsf_rst, m_load, m_gie, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {m_flags, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1; // Ready for answers throughout
    s_axi_rready = 1'b1;
    seed = 32'h9f5f302a;
    rst = 1'b1;
    en = '{default: 4'h0};
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd_all();
    axi_rd(8'h40, 32'h0, `IEG_RESP_SLVERR);
    axi_wr(addr[3], 4'hf, `IEG_RESP_SLVERR);
    axi_wr(8'hb5, 4'hf, `IEG_RESP_SLVERR);
    // Lane 0 strobe low: answered OKAY, register must keep its value
    s_axi_wstrb <= 4'he;
    axi_wr(addr[0], 4'hf, `IEG_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd_all();
    $display("test reset_and_bus done");
    // One enable bit at a time with every flag raised
    for (int k = 0; k < 12; k++) begin
      f = 12'h001 << k;
      set_en(f[3:0], f[7:4], f[11:8]);
      set_src(12'hfff, 1'b1);
      chk_irq(exp_irq(12'hfff, 1'b1));
    end
    $display("test bit_map done");
    // Everything set but the global enable
    set_en(4'hf, 4'hf, 4'hf);
    set_src(12'hfff, 1'b0);
    chk_irq(13'h0000);
    // Status: raw flags at 16 up, global enable at 12, gated pending below
    axi_rd(addr[3], 32'h0fff_0000, `IEG_RESP_OKAY);
    set_src(12'hfff, 1'b1);
    chk_irq({1'b1, `IEG_VEC_CE});
    set_src(12'h001, 1'b1);
    chk_irq({1'b1, `IEG_VEC_SER1});
    axi_rd(addr[3], 32'h0001_1001, `IEG_RESP_OKAY);
    $display("test global_enable done");
    repeat (40) begin
      seed = xs(seed);
      set_en(seed[3:0], seed[7:4], seed[11:8]);
      seed = xs(seed);
      f = seed[11:0];
      g = seed[12];
      set_src(f, g);
      chk_irq(exp_irq(f, g));
      rd_all();
    end
    $display("test random done");
    // Fault reset clears the enables while flags stay raised
    set_en(4'hf, 4'ha, 4'h5);
    set_src(12'hfff, 1'b1);
    wsf_rst <= 1'b1;
    @(posedge clock);
    wsf_rst <= 1'b0;
    en = '{default: 4'h0};
    rd_all();
    chk_irq(13'h0000);
    // Power-on reset in mid-run
    set_en(4'h3, 4'hc, 4'h9);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    en = '{default: 4'h0};
    rd_all();
    chk_irq(13'h0000);
    $display("test resets done");
    summarize();
  end
endmodule
`default_nettype wire
